// >>> rtl/adsq_top.sv
// converter sequencing, completion flag and result register control with apb slave
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - channel write leaves completion flag untouched
// - old channel result may complete before switch
// - first result suspect if started early/disabled
// - mode/channel write restarts the conversion; result registers are left intact
// - start 0, enable 1 powers comparator only
// - result read beats store; store follows after
// - mode/channel write beats end; result dropped
// - three-bit field bits 5:3 selects time
module adsq_top #(
  parameter int RES_W = 10,
  parameter int CHAN_W = 2
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [RES_W-1:0] sample_data_i,
  output logic [CHAN_W-1:0] chan_sel_o,
  output logic comparator_pwr_o,
  output logic sar_active_o,
  output logic conv_done_irq_o
);
  logic rst_meta_b;
  logic rst_sync_b;
  adsq_pkg::adsq_mode_t converter_mode_reg;
  logic [CHAN_W-1:0] channel_select_reg;
  logic [RES_W-1:0] result_reg;
  logic conv_done_flag;
  logic first_suspect;
  logic cur_suspect;
  logic [15:0] settle_cnt;
  logic [15:0] conv_cnt;
  adsq_pkg::adsq_state_t state;
  logic pend_store;
  logic [RES_W-1:0] pend_data;
  logic acc;
  logic wr;
  logic rd;
  logic wr_mode;
  logic wr_chan;
  logic wr_stat;
  logic rd_result;
  logic mapped;
  logic conv_end;
  logic store_now;
  logic [RES_W-1:0] store_data;
  logic [31:0] next_rdata;

  function automatic logic [15:0] conv_cycles(input logic [2:0] sel);
    conv_cycles = 16'((32'(sel) + 32'd1) * 32'(adsq_pkg::CONV_UNIT_CYC));
  endfunction : conv_cycles

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i;
  assign rd = acc && !pwrite_i;
  assign wr_mode = wr && (paddr_i == adsq_pkg::OFF_MODE);
  assign wr_chan = wr && (paddr_i == adsq_pkg::OFF_CHAN);
  assign wr_stat = wr && (paddr_i == adsq_pkg::OFF_STATUS);
  // reading either result view counts as a result read
  assign rd_result = rd && ((paddr_i == adsq_pkg::OFF_RESULT) ||
                            (paddr_i == adsq_pkg::OFF_RESULT_HI));
  assign mapped = (paddr_i == adsq_pkg::OFF_MODE) || (paddr_i == adsq_pkg::OFF_CHAN) ||
                  (paddr_i == adsq_pkg::OFF_RESULT) || (paddr_i == adsq_pkg::OFF_RESULT_HI) ||
                  (paddr_i == adsq_pkg::OFF_STATUS);
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !mapped;

  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      converter_mode_reg <= adsq_pkg::MODE_RESET;
    else if (wr_mode)
      converter_mode_reg <= adsq_pkg::adsq_mode_t'(pwdata_i[7:0] & 8'hB9);
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      channel_select_reg <= CHAN_W'(adsq_pkg::CHAN_RESET);
    else if (wr_chan)
      channel_select_reg <= pwdata_i[CHAN_W-1:0];
  end

  // settle timer restarts whenever the enable bit rises or is off
  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      settle_cnt <= 16'h0000;
    else if (!converter_mode_reg.enable)
      settle_cnt <= 16'h0000;
    else if (settle_cnt < 16'(adsq_pkg::SETTLE_CYC))
      settle_cnt <= settle_cnt + 16'h0001;
  end

  // a start that sees the bias unsettled marks the first result as suspect
  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      first_suspect <= 1'b0;
    else if (wr_mode && pwdata_i[adsq_pkg::MODE_START_POS] && !converter_mode_reg.start)
      first_suspect <= !pwdata_i[adsq_pkg::MODE_ENABLE_POS] ||
                       !converter_mode_reg.enable ||
                       (settle_cnt < 16'(adsq_pkg::SETTLE_CYC));
    else if (store_now)
      first_suspect <= 1'b0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      state <= adsq_pkg::ADSQ_OFF;
    else
      case ({converter_mode_reg.start, converter_mode_reg.enable})
        2'b01: state <= adsq_pkg::ADSQ_WAIT;
        2'b10, 2'b11: state <= adsq_pkg::ADSQ_CONV;
        default: state <= adsq_pkg::ADSQ_OFF;
      endcase
  end

  assign comparator_pwr_o = (state != adsq_pkg::ADSQ_OFF);
  assign sar_active_o = (state == adsq_pkg::ADSQ_CONV);
  assign chan_sel_o = channel_select_reg;

  // conversion timer; a mode or channel write restarts it on the new setting
  // the conversion in flight is abandoned; the result register keeps its last stored result
  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      conv_cnt <= 16'h0000;
    else if (state != adsq_pkg::ADSQ_CONV || wr_mode || wr_chan)
      conv_cnt <= 16'h0000;
    else if (conv_end)
      conv_cnt <= 16'h0000;
    else
      conv_cnt <= conv_cnt + 16'h0001;
  end

  assign conv_end = (state == adsq_pkg::ADSQ_CONV) &&
                    (conv_cnt == conv_cycles(converter_mode_reg.tsel) - 16'h0001);

  // an end in the write cycle is dropped; an end in a result read waits a cycle
  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      pend_store <= 1'b0;
      pend_data <= '0;
    end
    else if (conv_end && !(wr_mode || wr_chan) && rd_result)
    begin
      pend_store <= 1'b1;
      pend_data <= sample_data_i;
    end
    else if (!rd_result)
      pend_store <= 1'b0;
  end

  assign store_now = !rd_result && (pend_store ||
                     (conv_end && !(wr_mode || wr_chan)));
  assign store_data = pend_store ? pend_data : sample_data_i;

  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      result_reg <= '0;
      cur_suspect <= 1'b0;
    end
    else if (store_now)
    begin
      result_reg <= store_data;
      cur_suspect <= first_suspect;
    end
  end

  // set beats clear; a channel write never touches the flag
  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      conv_done_flag <= 1'b0;
    else if (store_now)
      conv_done_flag <= 1'b1;
    else if (wr_stat && pwdata_i[adsq_pkg::STAT_DONE_POS])
      conv_done_flag <= 1'b0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      conv_done_irq_o <= 1'b0;
    else
      conv_done_irq_o <= store_now;
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (paddr_i)
      adsq_pkg::OFF_MODE: next_rdata = {24'h000000, 8'(converter_mode_reg)};
      adsq_pkg::OFF_CHAN: next_rdata = 32'(channel_select_reg);
      adsq_pkg::OFF_RESULT: next_rdata = 32'(result_reg);
      adsq_pkg::OFF_RESULT_HI: next_rdata = 32'(result_reg[RES_W-1 -: 8]);
      adsq_pkg::OFF_STATUS: next_rdata = {30'h0, cur_suspect, conv_done_flag};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data is registered, so it is valid from the setup cycle's following edge
  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      prdata_o <= 32'h0000_0000;
    else if (psel_i && !pwrite_i)
      prdata_o <= next_rdata;
  end
endmodule : adsq_top
`default_nettype wire

// >>> rtl/adsq_pkg.sv
// package: register map, field layout and timing for the converter control block
package adsq_pkg;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CHAN = 8'h04;
  localparam logic [7:0] OFF_RESULT = 8'h08;
  localparam logic [7:0] OFF_RESULT_HI = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam int MODE_START_POS = 7;
  localparam int MODE_TSEL_LSB = 3;
  localparam int MODE_ENABLE_POS = 0;
  localparam int STAT_DONE_POS = 0;
  localparam int STAT_SUSPECT_POS = 1;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [1:0] CHAN_RESET = 2'h0;
  localparam int CLK_HZ = 20000000;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CONV_UNIT_CYC = 16;
  typedef struct packed {
    logic start;
    logic rsvd6;
    logic [2:0] tsel;
    logic [1:0] rsvd2;
    logic enable;
  } adsq_mode_t;
  typedef enum {ADSQ_OFF, ADSQ_WAIT, ADSQ_CONV} adsq_state_t;
endpackage : adsq_pkg

// >>> bench/adsq_props.sv
// checker: converter control relations seen at the block's ports
`timescale 1ns/1ps
`default_nettype none
module adsq_props (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [1:0] chan_sel_o,
  input wire logic comparator_pwr_o,
  input wire logic sar_active_o,
  input wire logic conv_done_irq_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  wire logic wr = psel_i & penable_i & pwrite_i;
  wire logic wm = wr & (paddr_i == adsq_pkg::OFF_MODE);
  wire logic wc = wr & (paddr_i == adsq_pkg::OFF_CHAN);
  wire logic [1:0] wch = pwdata_i[1:0];
  chk_irq_pulse_gap: assert property (conv_done_irq_o |=> !conv_done_irq_o [*8])
    else $error("irq pulse too long or too close");
  chk_irq_after_conv: assert property (conv_done_irq_o |-> $past(sar_active_o, 2))
    else $error("irq without conversion");
  chk_conv_keeps_comp: assert property (sar_active_o |-> comparator_pwr_o)
    else $error("converting with comparator off");
  // the state follows the mode register one edge later, hence two cycles
  chk_wait_state: assert property (wm && !pwdata_i[7] && pwdata_i[0] |->
    ##2 comparator_pwr_o && !sar_active_o)
    else $error("waiting state wrong");
  chk_stop_state: assert property (wm && !pwdata_i[7] && !pwdata_i[0] |->
    ##2 !comparator_pwr_o)
    else $error("comparator still powered");
  chk_start_runs: assert property (wm && pwdata_i[7] |-> ##2 sar_active_o [*2])
    else $error("start did not convert");
  chk_chan_follow: assert property (wc |=> chan_sel_o == $past(wch))
    else $error("channel not taken");
  chk_write_no_irq: assert property (wm || wc |=> !conv_done_irq_o)
    else $error("irq despite register write");
endmodule : adsq_props
bind adsq_top adsq_props u_chk (.sys_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .chan_sel_o, .comparator_pwr_o, .sar_active_o, .conv_done_irq_o);
`default_nettype wire

// >>> bench/adsq_src.sv
// analog input model: each channel presents its own fixed level
`timescale 1ns/1ps
`default_nettype none
module adsq_src (
  input wire logic [1:0] chan_i,
  output logic [9:0] level_o
);
  // channel number in the top bits so a stale channel shows
  assign level_o = {chan_i, 8'h5A};
endmodule : adsq_src
`default_nettype wire

// >>> bench/adsq_top_tb.sv
// testbench: apb scenarios for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adsq_top_tb;
  localparam logic [7:0] MD = adsq_pkg::OFF_MODE;
  localparam logic [7:0] ST = adsq_pkg::OFF_STATUS;
  logic clk = 0, rst_b = 0, sel = 0, en = 0, wr = 0, rdy, err, pwr, act, irq;
  logic slv_err;
  logic [7:0] a = 0;
  logic [31:0] wd = 0, rd, prd;
  logic [1:0] ch;
  logic [9:0] lvl;
  int mismatches = 0, total_checks = 0, n;
  always #25 clk = ~clk;
  adsq_src src (.chan_i(ch), .level_o(lvl));
  adsq_top dut (.sys_clk_i(clk), .rst_b_i(rst_b), .psel_i(sel), .penable_i(en),
    .pwrite_i(wr), .paddr_i(a), .pwdata_i(wd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(err), .sample_data_i(lvl), .chan_sel_o(ch), .comparator_pwr_o(pwr),
    .sar_active_o(act), .conv_done_irq_o(irq));
  task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
    total_checks++;
    if (v !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", s, e, v);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    sel <= 1;
    wr <= w;
    a <= ad;
    wd <= d;
    @(posedge clk);
    en <= 1;
    @(posedge clk);
    while (rdy !== 1'b1)
      @(posedge clk);
    rd = prd;
    slv_err = err;
    sel <= 0;
    en <= 0;
  endtask : bus
  // counts cycles up to the next irq pulse, sampled where settled
  task automatic wirq();
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (irq !== 1'b1);
  endtask : wirq
  task automatic t_regs();
    bus(0, MD, 0);
    chk("mode rst", rd, 0);
    bus(0, 8'h14, 0);
    chk("unmapped", {slv_err, rd[30:0]}, 32'h80000000);
    bus(1, MD, 32'hFF);
    bus(0, MD, 0);
    chk("mode bits", rd, 32'hB9);
    bus(1, MD, 0);
    // state follows the mode register one edge after the write
    repeat (2) @(negedge clk);
    chk("stopped", {pwr, act}, 0);
  endtask : t_regs
  task automatic t_period();
    for (int s = 0; s < 8; s++)
    begin
      bus(1, MD, 32'h81 | (s << 3));
      wirq();
      wirq();
      chk("period", n, (s + 1) * adsq_pkg::CONV_UNIT_CYC);
    end
    bus(0, adsq_pkg::OFF_RESULT, 0);
    chk("result", rd, 32'h05A);
    bus(0, adsq_pkg::OFF_RESULT_HI, 0);
    chk("result hi", rd, 32'h16);
  endtask : t_period
  task automatic t_chan();
    bus(1, adsq_pkg::OFF_CHAN, 2);
    bus(0, ST, 0);
    chk("flag kept", rd[0], 1);
    bus(1, ST, 1);
    wirq();
    bus(0, adsq_pkg::OFF_RESULT, 0);
    chk("new chan", rd, 32'h25A);
  endtask : t_chan
  task automatic t_first();
    bus(1, MD, 0);
    bus(1, ST, 1);
    bus(1, MD, 32'h80);
    wirq();
    bus(0, ST, 0);
    chk("suspect", rd[1:0], 2'b11);
    bus(1, MD, 0);
    bus(1, ST, 1);
    bus(1, MD, 1);
    repeat (2) @(negedge clk);
    chk("waiting", {pwr, act}, 2'b10);
    repeat (adsq_pkg::SETTLE_CYC + 2) @(posedge clk);
    bus(1, MD, 32'h81);
    wirq();
    bus(0, ST, 0);
    chk("clean", rd[1:0], 2'b01);
  endtask : t_first
  // access phase placed on the conversion end: 13 idle edges plus the setup cycle
  task automatic t_clash();
    wirq();
    repeat (13) @(posedge clk);
    bus(0, adsq_pkg::OFF_RESULT, 0);
    wirq();
    chk("read first", n, 2);
    wirq();
    repeat (13) @(posedge clk);
    bus(1, MD, 32'h81);
    wirq();
    chk("write wins", n, adsq_pkg::CONV_UNIT_CYC + 1);
    bus(1, MD, 0);
    repeat (2) @(negedge clk);
    chk("idle", {pwr, act}, 0);
  endtask : t_clash
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1;
    repeat (3) @(posedge clk);
    t_regs();
    t_period();
    t_chan();
    t_first();
    t_clash();
    stop_test();
  end
  // the run needs under 3000 cycles
  initial
  begin
    #400000;
    mismatches++;
    stop_test();
  end
endmodule : adsq_top_tb
`default_nettype wire
